// >>> sram_host_pkg.sv
// package for the asynchronous static ram host controller
// assumes a single 40 MHz clock; times in ns are given here, and min_cycles turns them into cycle counts
`default_nettype none
package sram_host_pkg;
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned ADDR_W        = 15;
	localparam int unsigned DATA_W        = 8;
	localparam int unsigned WORDS         = 32768;
	// fast grade figures, slow grade selectable by parameter
	localparam int unsigned WRITE_PULSE_FAST_NS   = 140;
	localparam int unsigned WRITE_PULSE_SLOW_NS   = 200;
	localparam int unsigned SELECT_LOW_OVERLAP_FAST_NS = 150;
	localparam int unsigned SELECT_LOW_OVERLAP_SLOW_NS = 250;
	localparam int unsigned WRITE_TO_FLOAT_MAX_FAST_NS = 60;
	localparam int unsigned WRITE_TO_FLOAT_MAX_SLOW_NS = 120;
	localparam int unsigned SELECT_TO_FLOAT_MAX_FAST_NS = 60;
	localparam int unsigned SELECT_TO_FLOAT_MAX_SLOW_NS = 120;
	localparam int unsigned READ_CYCLE_PERIOD_FAST_NS = 200;
	localparam int unsigned READ_CYCLE_PERIOD_SLOW_NS = 500;
	localparam int unsigned SELECT_WRITE_RECOVERY_NS  = 0;
	localparam int unsigned RETENTION_SELECT_SETUP_NS = 0;
	// least times round up to whole cycles, never below one
	function automatic int unsigned min_cycles(input int unsigned ns);
		int unsigned c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : min_cycles
	localparam int unsigned CNT_W = 8;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	// request carried from the user side
	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} sram_req_s;
	// pins driven toward the memory
	typedef struct packed {
		logic              select_n;
		logic              output_en_n;
		logic              write_n;
		logic [ADDR_W-1:0] address_lines;
		logic [DATA_W-1:0] data_out;
		logic              data_oe;
	} sram_pins_s;
	typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_WR_FLOAT, ST_WR, ST_GAP, ST_RETAIN, ST_WAKE} state_e;
endpackage : sram_host_pkg
`default_nettype wire

// >>> sram_host.sv
// host side controller for a 32768 x 8 asynchronous static ram at 3 V
// assumes the memory pins are reached directly; data_lines are split into in, out and enable
// How it works
// - write strobe stays high throughout reads
// - never drive data while memory drives
// - output enable held fixed during writes
// - write strobe low long enough, grade dependent
// - select low long enough, grade dependent
// - address may change right after select rises
// - select high before and during retention
// - select high one read period after wake
`default_nettype none
module sram_host #(
	parameter bit SLOW_GRADE = 1'b0
) (
	// clock and reset
	input  wire logic                                i_clk,
	input  wire logic                                i_rst,
	// user request side
	input  wire logic                                i_req_valid,
	input  wire sram_host_pkg::sram_req_s            i_req,
	output logic                                     o_req_ready,
	output logic                                     o_rd_valid,
	output logic [sram_host_pkg::DATA_W-1:0]         o_rd_data,
	// retention control
	input  wire logic                                i_retain,
	output logic                                     o_retained,
	// memory pins
	output sram_host_pkg::sram_pins_s                o_pins,
	input  wire logic [sram_host_pkg::DATA_W-1:0]    i_data_lines
);
	localparam int unsigned WP_NS   = SLOW_GRADE ? sram_host_pkg::WRITE_PULSE_SLOW_NS
	                                             : sram_host_pkg::WRITE_PULSE_FAST_NS;
	localparam int unsigned CW_NS   = SLOW_GRADE ? sram_host_pkg::SELECT_LOW_OVERLAP_SLOW_NS
	                                             : sram_host_pkg::SELECT_LOW_OVERLAP_FAST_NS;
	localparam int unsigned FLT_NS  = SLOW_GRADE ? sram_host_pkg::WRITE_TO_FLOAT_MAX_SLOW_NS
	                                             : sram_host_pkg::WRITE_TO_FLOAT_MAX_FAST_NS;
	localparam int unsigned CFL_NS  = SLOW_GRADE ? sram_host_pkg::SELECT_TO_FLOAT_MAX_SLOW_NS
	                                             : sram_host_pkg::SELECT_TO_FLOAT_MAX_FAST_NS;
	localparam int unsigned RC_NS   = SLOW_GRADE ? sram_host_pkg::READ_CYCLE_PERIOD_SLOW_NS
	                                             : sram_host_pkg::READ_CYCLE_PERIOD_FAST_NS;
	// the write phase must satisfy both the strobe width and the select overlap
	localparam int unsigned WR_NS   = (WP_NS > CW_NS) ? WP_NS : CW_NS;
	localparam logic [7:0] WR_CYC   = 8'(sram_host_pkg::min_cycles(WR_NS));
	localparam logic [7:0] FLT_CYC  = 8'(sram_host_pkg::min_cycles(FLT_NS));
	localparam logic [7:0] CFL_CYC  = 8'(sram_host_pkg::min_cycles(CFL_NS));
	localparam logic [7:0] RC_CYC   = 8'(sram_host_pkg::min_cycles(RC_NS));

	// state names as local constants, since nothing is imported from the package
	localparam sram_host_pkg::state_e ST_IDLE     = sram_host_pkg::ST_IDLE;
	localparam sram_host_pkg::state_e ST_RD       = sram_host_pkg::ST_RD;
	localparam sram_host_pkg::state_e ST_WR_FLOAT = sram_host_pkg::ST_WR_FLOAT;
	localparam sram_host_pkg::state_e ST_WR       = sram_host_pkg::ST_WR;
	localparam sram_host_pkg::state_e ST_GAP      = sram_host_pkg::ST_GAP;
	localparam sram_host_pkg::state_e ST_RETAIN   = sram_host_pkg::ST_RETAIN;
	localparam sram_host_pkg::state_e ST_WAKE     = sram_host_pkg::ST_WAKE;

	sram_host_pkg::state_e                 state_q, state_d;
	logic [7:0]                            cnt_q, cnt_d;
	sram_host_pkg::sram_req_s              req_q, req_d;
	sram_host_pkg::sram_pins_s             pins_q, pins_d;
	logic [sram_host_pkg::DATA_W-1:0]      sync1_q, sync2_q;
	logic                                  ret1_q, ret2_q;
	logic                                  rd_valid_q, rd_valid_d;
	logic [sram_host_pkg::DATA_W-1:0]      rd_data_q, rd_data_d;

	// pin inputs pass two flops before use
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
			ret1_q  <= 1'b0;
			ret2_q  <= 1'b0;
		end
		else
		begin
			sync1_q <= i_data_lines;
			sync2_q <= sync1_q;
			ret1_q  <= i_retain;
			ret2_q  <= ret1_q;
		end
	end

	// sequencer: next pin levels, counts and captured data
	always_comb
	begin
		state_d    = state_q;
		cnt_d      = (cnt_q == sram_host_pkg::CNT_ZERO) ? cnt_q : cnt_q - 8'h01;
		req_d      = req_q;
		pins_d     = pins_q;
		rd_valid_d = 1'b0;
		rd_data_d  = rd_data_q;
		case (state_q)
			ST_IDLE:
			begin
				pins_d.select_n    = 1'b1;
				pins_d.output_en_n = 1'b1;
				pins_d.write_n     = 1'b1;
				pins_d.data_oe     = 1'b0;
				if (ret2_q)
					state_d = ST_RETAIN;                    // select already high
				else if (i_req_valid)
				begin
					req_d                = i_req;
					pins_d.address_lines = i_req.addr;
					pins_d.select_n      = 1'b0;
					if (i_req.write)
					begin
						// enable stays high for the whole write, memory is already floating
						state_d = ST_WR_FLOAT;
						cnt_d   = FLT_CYC;
					end
					else
					begin
						pins_d.output_en_n = 1'b0;
						state_d            = ST_RD;
						cnt_d              = RC_CYC;        // full read cycle period
					end
				end
			end
			ST_RD:
			begin
				pins_d.write_n = 1'b1;
				pins_d.data_oe = 1'b0;
				if (cnt_q == sram_host_pkg::CNT_ZERO)
				begin
					rd_data_d          = sync2_q;
					rd_valid_d         = 1'b1;
					pins_d.select_n    = 1'b1;
					pins_d.output_en_n = 1'b1;
					state_d            = ST_GAP;
					cnt_d              = CFL_CYC;           // wait for float
				end
			end
			ST_WR_FLOAT:
			begin
				// strobe falls; our drive waits for the memory float time
				pins_d.write_n = 1'b0;
				if (cnt_q == sram_host_pkg::CNT_ZERO)
				begin
					pins_d.data_out = req_q.wdata;
					pins_d.data_oe  = 1'b1;
					state_d         = ST_WR;
					cnt_d           = WR_CYC;
				end
			end
			ST_WR:
			begin
				if (cnt_q == sram_host_pkg::CNT_ZERO)
				begin
					// select and strobe rise together, data held this edge
					pins_d.write_n  = 1'b1;
					pins_d.select_n = 1'b1;
					state_d         = ST_GAP;
					cnt_d           = 8'h01;
				end
			end
			ST_GAP:
			begin
				pins_d.data_oe = 1'b0;
				if (cnt_q == sram_host_pkg::CNT_ZERO)
					state_d = ST_IDLE;
			end
			ST_RETAIN:
			begin
				pins_d.select_n = 1'b1;
				if (!ret2_q)
				begin
					state_d = ST_WAKE;
					cnt_d   = RC_CYC;
				end
			end
			ST_WAKE:
			begin
				pins_d.select_n = 1'b1;
				if (cnt_q == sram_host_pkg::CNT_ZERO)
					state_d = ST_IDLE;
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	// state registers
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_q    <= ST_IDLE;
			cnt_q      <= sram_host_pkg::CNT_ZERO;
			req_q      <= '0;
			pins_q     <= '{select_n: 1'b1, output_en_n: 1'b1, write_n: 1'b1,
			                address_lines: '0, data_out: '0, data_oe: 1'b0};
			rd_valid_q <= 1'b0;
			rd_data_q  <= '0;
		end
		else
		begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			req_q      <= req_d;
			pins_q     <= pins_d;
			rd_valid_q <= rd_valid_d;
			rd_data_q  <= rd_data_d;
		end
	end

	// outputs
	assign o_pins      = pins_q;
	assign o_rd_valid  = rd_valid_q;
	assign o_rd_data   = rd_data_q;
	assign o_req_ready = (state_q == ST_IDLE) && !ret2_q;
	assign o_retained  = (state_q == ST_RETAIN);
endmodule : sram_host
`default_nettype wire

// >>> sram_host_sva.sv
// checker for the static ram host controller pins
// assumes sram_host at its default fast grade
`default_nettype none
module sram_host_chk (
	input wire logic                      i_clk,
	input wire logic                      i_rst,
	input wire logic                      o_retained,
	input wire sram_host_pkg::sram_pins_s o_pins
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// strobe relations driven by the host
	property p_rdwe; !o_pins.select_n && !o_pins.output_en_n |-> o_pins.write_n; endproperty
	a_rdwe: assert property (p_rdwe) else $error("write low in read");
	property p_clash; o_pins.data_oe |-> o_pins.output_en_n; endproperty
	a_clash: assert property (p_clash) else $error("drive while enabled");
	property p_oefix; !o_pins.select_n && !o_pins.write_n |-> $stable(o_pins.output_en_n); endproperty
	a_oefix: assert property (p_oefix) else $error("enable moved in write");
	property p_wp; $fell(o_pins.write_n) |-> (!o_pins.write_n && !o_pins.select_n)[*6]; endproperty
	a_wp: assert property (p_wp) else $error("write pulse short");
	property p_cw; $fell(o_pins.select_n) && o_pins.output_en_n |-> (!o_pins.select_n)[*7]; endproperty
	a_cw: assert property (p_cw) else $error("select low short");
	property p_hold; $rose(o_pins.select_n) && $past(o_pins.output_en_n) |-> o_pins.data_oe; endproperty
	a_hold: assert property (p_hold) else $error("data not held");
	property p_ret; o_retained |-> o_pins.select_n; endproperty
	a_ret: assert property (p_ret) else $error("select low in retention");
	property p_wake; $fell(o_retained) |-> o_pins.select_n[*8]; endproperty
	a_wake: assert property (p_wake) else $error("select low after wake");
	// main scenarios
	c_rd: cover property ($fell(o_pins.output_en_n));
	c_wr: cover property ($fell(o_pins.write_n));
	c_ret: cover property ($fell(o_retained));
endmodule : sram_host_chk
bind sram_host sram_host_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .o_retained(o_retained), .o_pins(o_pins));
`default_nettype wire

// >>> sram_model.sv
// behavioural 32768 x 8 static ram on the host pins
// assumes the host never drives while the memory drives
`default_nettype none
module sram_model (
	// pins from the host
	input  wire sram_host_pkg::sram_pins_s i_pins,
	// resolved data_lines level
	output logic [7:0]                     o_data_lines
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:sram_host_pkg::WORDS-1];
	logic       drv;
	logic       drv_d = 1'b0;
	logic       flip = 1'b0;
	// memory drives only in a selected, enabled, non-write cycle
	assign drv = !i_pins.select_n && !i_pins.output_en_n && i_pins.write_n;
	// drive starts and ends 20 ns late, inside every window
	always @(drv) drv_d <= #20 drv;
	// undriven lines wander
	always #7 flip = ~flip;
	// write lands when a strobe rises with host data present
	always @(posedge i_pins.write_n or posedge i_pins.select_n)
		if (i_pins.data_oe === 1'b1) mem[i_pins.address_lines] = i_pins.data_out;
	// wire level
	assign o_data_lines = i_pins.data_oe ? i_pins.data_out : drv_d ? mem[i_pins.address_lines] : {4{flip, ~flip}};
endmodule : sram_model
`default_nettype wire

// >>> sram_host_bench.sv
// self-checking bench for sram_host with a memory model
// assumes the fast grade and a 40 MHz clock
`default_nettype none
module sram_host_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk, i_rst, i_req_valid, i_retain, o_req_ready, o_rd_valid, o_retained;
	logic [7:0] o_rd_data, lines;
	sram_host_pkg::sram_req_s  i_req;
	sram_host_pkg::sram_pins_s o_pins;
	int err_count, n_compared, cycles;
	sram_host u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req(i_req),
		.o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .i_retain(i_retain),
		.o_retained(o_retained), .o_pins(o_pins), .i_data_lines(lines));
	sram_model u_mem (.i_pins(o_pins), .o_data_lines(lines));
	// clock
	initial
	begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	// hang guard
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// one request, held until taken; ready must drop once busy
	task automatic access(input logic wr, input logic [14:0] a, input logic [7:0] d);
		int n;
		@(posedge i_clk);
		i_req_valid <= 1'b1;
		i_req <= '{write: wr, addr: a, wdata: d};
		for (n = 0; n < 60; n++)
		begin
			@(negedge i_clk);
			if (o_req_ready === 1'b1) break;
		end
		@(posedge i_clk);
		i_req_valid <= 1'b0;
		@(negedge i_clk);
		chk("busy_ready", 8'h00, {7'h00, o_req_ready});
	endtask : access
	task automatic rd(input logic [14:0] a, input logic [7:0] exp);
		int n;
		access(1'b0, a, 8'h00);
		for (n = 0; n < 40 && o_rd_valid !== 1'b1; n++) @(negedge i_clk);
		chk("rd_valid", 8'h01, {7'h00, o_rd_valid});
		chk("rd_data", exp, o_rd_data);
	endtask : rd
	// boundary addresses and patterns, then overwrite
	task automatic t_write_read();
		logic [14:0] a [3] = '{15'h0000, 15'h7fff, 15'h1234};
		logic [7:0]  d [3] = '{8'ha5, 8'h5a, 8'hff};
		foreach (a[i]) access(1'b1, a[i], d[i]);
		foreach (a[i]) rd(a[i], d[i]);
		access(1'b1, 15'h0010, 8'h11);
		access(1'b1, 15'h0010, 8'h22);
		rd(15'h0010, 8'h22);
	endtask : t_write_read
	// retention keeps select high and data intact
	task automatic t_retain();
		int n;
		access(1'b1, 15'h0020, 8'h3c);
		@(posedge i_clk);
		i_retain <= 1'b1;
		for (n = 0; n < 40 && o_retained !== 1'b1; n++) @(negedge i_clk);
		chk("retain_select", 8'h01, {7'h00, o_pins.select_n});
		@(posedge i_clk);
		i_retain <= 1'b0;
		for (n = 0; n < 60 && !(o_retained === 1'b0 && o_req_ready === 1'b1); n++) @(negedge i_clk);
		chk("wake_wait", 8'h01, {7'h00, n >= 8});
		rd(15'h0020, 8'h3c);
	endtask : t_retain
	// main sequence
	initial
	begin
		i_rst = 1'b1;
		i_req_valid = 1'b0;
		i_retain = 1'b0;
		i_req = '0;
		repeat (12) @(posedge i_clk);
		i_rst <= 1'b0;
		@(negedge i_clk);
		chk("idle_select", 8'h01, {7'h00, o_pins.select_n});
		t_write_read();
		t_retain();
		report_and_stop();
	end
endmodule : sram_host_bench
`default_nettype wire
